// >>> include/fsh_poll_defines.svh
`ifndef FSH_POLL_DEFINES_SVH
`define FSH_POLL_DEFINES_SVH
// =====================================================================
// Clock and timing
`define FSH_CLK_NS       4
`define FSH_T_ACC_NS     120
`define FSH_T_WP_NS      40
`define FSH_T_RST_NS     2000
`define FSH_ACC_CYC      ((`FSH_T_ACC_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_WP_CYC       ((`FSH_T_WP_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_RST_CYC      (`FSH_T_RST_NS / `FSH_CLK_NS)
// =====================================================================
// Status word bit positions
`define FSH_BIT_POLL     7
`define FSH_BIT_TOG1     6
`define FSH_BIT_TMO      5
`define FSH_BIT_ERS      3
`define FSH_BIT_TOG2     2
`define FSH_BIT_ABT      1
`define FSH_STAT_MASK    16'h00ee
// =====================================================================
// Command words
`define FSH_CMD_RESET    16'h00f0
`define FSH_UNLK_A1      16'h0555
`define FSH_UNLK_D1      16'h00aa
`define FSH_UNLK_A2      16'h02aa
`define FSH_UNLK_D2      16'h0055
`define FSH_ABT_STEPS    2'h3
`endif

// >>> include/fsh_poll_pkg.sv
package fsh_poll_pkg;
  typedef enum logic [8:0] {
    FSH_IDLE = 9'h001,
    FSH_RD1  = 9'h002,
    FSH_RD2  = 9'h004,
    FSH_CHK  = 9'h008,
    FSH_RD3  = 9'h010,
    FSH_RST  = 9'h020,
    FSH_ABT  = 9'h040,
    FSH_WAIT = 9'h080,
    FSH_FIN  = 9'h100
  } fsh_state_t;
  typedef enum logic [2:0] {
    FSH_RES_OK   = 3'h0,
    FSH_RES_TMO  = 3'h1,
    FSH_RES_ABT  = 3'h2,
    FSH_RES_REF  = 3'h3,
    FSH_RES_LEFT = 3'h4
  } fsh_result_t;
endpackage

// >>> verilog/fsh_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsh_poll_defines.svh"
module fsh_bus_cycle
  import fsh_poll_pkg::*;
#(
  parameter int AW      = 26,
  parameter int ACC_CYC = `FSH_ACC_CYC,
  parameter int WP_CYC  = `FSH_WP_CYC
)(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          go,
  input  wire logic          wr,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   wdata,
  output logic               ack_ff,
  output logic [15:0]        rdata_ff,
  output logic [AW-1:0]      flash_addr_ff,
  output logic               ce_n_ff,
  output logic               oe_n_ff,
  output logic               we_n_ff,
  output logic [15:0]        dq_o_ff,
  output logic               dq_oe_ff,
  input  wire logic [15:0]   dq_i
);
  // ===================================================================
  // One strobed read or write cycle; data lines stay driven one cycle
  // past the write strobe so hold time is met.
  logic       act_ff;
  logic       rec_ff;
  logic       wr_ff;
  logic [7:0] cnt_ff;
  wire  [7:0] lim     = wr_ff ? 8'(WP_CYC) : 8'(ACC_CYC);
  wire        start   = go & ~act_ff & ~rec_ff;
  wire        strobe_end = act_ff & (cnt_ff == lim);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      act_ff <= 1'b0; rec_ff <= 1'b0; wr_ff <= 1'b0; cnt_ff <= 8'h00;
      ack_ff <= 1'b0; rdata_ff <= 16'h0000; flash_addr_ff <= '0;
      ce_n_ff <= 1'b1; oe_n_ff <= 1'b1; we_n_ff <= 1'b1;
      dq_o_ff <= 16'h0000; dq_oe_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= rec_ff;
      rec_ff <= strobe_end;
      cnt_ff <= start ? 8'h01 : (act_ff ? cnt_ff + 8'h01 : 8'h00);
      if (start)
      begin
        act_ff <= 1'b1; wr_ff <= wr; flash_addr_ff <= addr;
        ce_n_ff <= 1'b0; oe_n_ff <= wr; we_n_ff <= ~wr;
        dq_o_ff <= wdata; dq_oe_ff <= wr;
      end
      if (strobe_end)
      begin
        act_ff <= 1'b0; ce_n_ff <= 1'b1; oe_n_ff <= 1'b1; we_n_ff <= 1'b1;
        if (!wr_ff)
          rdata_ff <= dq_i;
      end
      if (rec_ff)
        dq_oe_ff <= 1'b0;
    end
  end
endmodule // fsh_bus_cycle
`default_nettype wire

// >>> verilog/fsh_poll_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsh_poll_defines.svh"
// Contract
// - Host reads status twice before toggle decision
// - Still toggling: check timeout flag, recheck toggle
// - Stopped means success; toggling means fail, reset
// - Timeout low: keep polling or restart later
// - After timeout host resets; device returns array
// - Abort recovery uses abort clear command sequence
// - Never read suspended program line
// - Poll at valid target address only
// - Reserved status bits masked as don't care
module fsh_poll_ctrl
  import fsh_poll_pkg::*;
#(
  parameter int AW      = 26,
  parameter int LINE_W  = 8,
  parameter int RST_CYC = `FSH_RST_CYC
)(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          poll_start,
  input  wire logic [AW-1:0] poll_addr,
  input  wire logic          abandon,
  input  wire logic          susp_en,
  input  wire logic [AW-1:0] susp_addr,
  output logic               done_ff,
  output fsh_result_t        result_ff,
  output logic [15:0]        status_ff,
  output logic               busy_ff,
  output logic [AW-1:0]      flash_addr_ff,
  output logic               ce_n_ff,
  output logic               oe_n_ff,
  output logic               we_n_ff,
  output logic [15:0]        dq_o_ff,
  output logic               dq_oe_ff,
  input  wire logic [15:0]   dq_i,
  input  wire logic          ready_busy_n
);
  // ===================================================================
  // Command words of the abort clear sequence
  function automatic logic [15:0] abt_addr(input logic [1:0] step);
    abt_addr = (step == 2'h1) ? `FSH_UNLK_A2 : `FSH_UNLK_A1;
  endfunction
  function automatic logic [15:0] abt_data(input logic [1:0] step);
    abt_data = (step == 2'h0) ? `FSH_UNLK_D1 : ((step == 2'h1) ? `FSH_UNLK_D2 : `FSH_CMD_RESET);
  endfunction

  // ===================================================================
  // State and bus glue
  fsh_state_t   st_ff, nxt_st;
  fsh_result_t  pend_ff, nxt_pend;
  logic [AW-1:0] addr_ff;
  logic [15:0]  d1_ff, d2_ff;
  logic         req_ff, rechk_ff;
  logic [1:0]   step_ff;
  logic [11:0]  wait_ff;
  logic [1:0]   rd_cnt_ff;
  logic         bus_ack;
  logic [15:0]  bus_rdata;

  wire bus_rd_st  = (st_ff == FSH_RD1) | (st_ff == FSH_RD2) | (st_ff == FSH_RD3);
  wire bus_wr_st  = (st_ff == FSH_RST) | (st_ff == FSH_ABT);
  wire bus_go     = (bus_rd_st | bus_wr_st) & ~req_ff & ~bus_ack;
  wire [AW-1:0] cmd_a = (st_ff == FSH_ABT) ? AW'(abt_addr(step_ff)) : addr_ff;
  wire [15:0]   cmd_d = (st_ff == FSH_ABT) ? abt_data(step_ff) : `FSH_CMD_RESET;
  wire [AW-1:0] go_addr = bus_wr_st ? cmd_a : addr_ff;
  // A poll aimed at a suspended program line would read invalid data
  wire susp_hit   = susp_en & (poll_addr[AW-1:LINE_W] == susp_addr[AW-1:LINE_W]);
  wire toggling   = d1_ff[`FSH_BIT_TOG1] ^ d2_ff[`FSH_BIT_TOG1];
  wire tmo_seen   = d2_ff[`FSH_BIT_TMO];
  wire abt_seen   = d2_ff[`FSH_BIT_ABT];
  wire wait_over  = ready_busy_n | (wait_ff >= 12'(RST_CYC));

  fsh_bus_cycle #(.AW(AW)) u_bus (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .go            (bus_go),
    .wr            (bus_wr_st),
    .addr          (go_addr),
    .wdata         (cmd_d),
    .ack_ff        (bus_ack),
    .rdata_ff      (bus_rdata),
    .flash_addr_ff (flash_addr_ff),
    .ce_n_ff       (ce_n_ff),
    .oe_n_ff       (oe_n_ff),
    .we_n_ff       (we_n_ff),
    .dq_o_ff       (dq_o_ff),
    .dq_oe_ff      (dq_oe_ff),
    .dq_i          (dq_i)
  );

  // ===================================================================
  // Toggle-bit algorithm
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_pend = pend_ff;
    case (st_ff)
      FSH_IDLE: if (poll_start) nxt_st = susp_hit ? FSH_FIN : FSH_RD1;
      FSH_RD1:  if (bus_ack) nxt_st = FSH_RD2;
      FSH_RD2:  if (bus_ack) nxt_st = FSH_CHK;
      FSH_RD3:  if (bus_ack) nxt_st = FSH_CHK;
      FSH_CHK:
      begin
        if (!toggling)
        begin
          nxt_st = FSH_FIN;
          nxt_pend = FSH_RES_OK;
        end
        // Either flag may come from array data of a read that straddled
        // completion, so the toggle is read once more before acting on it
        else if (abt_seen || tmo_seen)
        begin
          nxt_st = !rechk_ff ? FSH_RD3 : (abt_seen ? FSH_ABT : FSH_RST);
          nxt_pend = abt_seen ? FSH_RES_ABT : FSH_RES_TMO;
        end
        else if (abandon)
        begin
          nxt_st = FSH_FIN;
          nxt_pend = FSH_RES_LEFT;
        end
        else
          nxt_st = FSH_RD1;
      end
      FSH_RST:  if (bus_ack) nxt_st = FSH_WAIT;
      FSH_ABT:  if (bus_ack && step_ff == `FSH_ABT_STEPS - 2'h1) nxt_st = FSH_WAIT;
      FSH_WAIT: if (wait_over) nxt_st = FSH_FIN;
      FSH_FIN:  nxt_st = FSH_IDLE;
      default:  nxt_st = FSH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= FSH_IDLE; pend_ff <= FSH_RES_OK; addr_ff <= '0;
      d1_ff <= 16'h0000; d2_ff <= 16'h0000; req_ff <= 1'b0;
      rechk_ff <= 1'b0; step_ff <= 2'h0; wait_ff <= 12'h000;
    end
    else
    begin
      st_ff   <= nxt_st;
      pend_ff <= (st_ff == FSH_IDLE) ? (susp_hit ? FSH_RES_REF : FSH_RES_OK) : nxt_pend;
      req_ff  <= bus_go | (req_ff & ~bus_ack);
      if (st_ff == FSH_IDLE && poll_start)
        addr_ff <= poll_addr;
      if (bus_ack && st_ff == FSH_RD1)
        d1_ff <= bus_rdata;
      if (bus_ack && (st_ff == FSH_RD2 || st_ff == FSH_RD3))
      begin
        d2_ff <= bus_rdata;
        d1_ff <= (st_ff == FSH_RD3) ? d2_ff : d1_ff;
      end
      rechk_ff <= (st_ff == FSH_IDLE || st_ff == FSH_RD1) ? 1'b0 : (rechk_ff | (st_ff == FSH_RD3));
      step_ff  <= (st_ff != FSH_ABT) ? 2'h0 : step_ff + 2'(bus_ack);
      wait_ff  <= (st_ff == FSH_WAIT) ? wait_ff + 12'h001 : 12'h000;
    end
  end

  // ===================================================================
  // Results; reserved status bits are never passed on
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_ff <= 1'b0; result_ff <= FSH_RES_OK; status_ff <= 16'h0000; busy_ff <= 1'b0;
    end
    else
    begin
      done_ff <= (st_ff == FSH_FIN);
      busy_ff <= (nxt_st != FSH_IDLE);
      if (st_ff == FSH_FIN)
        result_ff <= pend_ff;
      if (st_ff == FSH_CHK)
        status_ff <= d2_ff & `FSH_STAT_MASK;
    end
  end

  // ===================================================================
  // Checks
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_cnt_ff <= 2'h0;
    else if (st_ff == FSH_IDLE || (st_ff == FSH_CHK && nxt_st == FSH_RD1))
      rd_cnt_ff <= 2'h0;
    else if (bus_ack && bus_rd_st && rd_cnt_ff != 2'h3)
      rd_cnt_ff <= rd_cnt_ff + 2'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_double_read: assert property (st_ff == FSH_CHK |-> rd_cnt_ff >= 2'h2)
    else $error("toggle decided before two reads");
  a_tmo_recheck: assert property ($rose(st_ff == FSH_RD3) |-> $past(toggling && (tmo_seen || abt_seen)))
    else $error("recheck read without a raised flag");
  a_fail_reset: assert property (st_ff == FSH_CHK && toggling && !abt_seen && tmo_seen && rechk_ff
    |=> st_ff == FSH_RST ##[1:100] (!we_n_ff && dq_o_ff == `FSH_CMD_RESET))
    else $error("reset command not written after failure");
  a_restart_top: assert property (st_ff == FSH_CHK && nxt_st == FSH_RD1 |=> rd_cnt_ff == 2'h0)
    else $error("restart did not begin with a fresh double read");
  a_reset_wait: assert property (st_ff == FSH_WAIT |-> wait_ff <= 12'(RST_CYC))
    else $error("busy wait after reset too long");
  a_abort_seq: assert property (st_ff == FSH_CHK && toggling && abt_seen && rechk_ff |=> st_ff == FSH_ABT [*3])
    else $error("abort clear sequence not started");
  a_no_susp_line: assert property (poll_start && st_ff == FSH_IDLE && susp_hit
    |=> st_ff == FSH_FIN ##1 (done_ff && result_ff == FSH_RES_REF))
    else $error("suspended line was polled");
  a_target_addr: assert property (bus_go && bus_rd_st |=> flash_addr_ff == addr_ff && !oe_n_ff)
    else $error("status read at wrong address");
  a_masked_status: assert property ((status_ff & ~`FSH_STAT_MASK) == 16'h0000)
    else $error("reserved status bits passed on");

  c_poll_ok:  cover property (done_ff && result_ff == FSH_RES_OK);
  c_poll_tmo: cover property (done_ff && result_ff == FSH_RES_TMO);
  c_poll_abt: cover property (done_ff && result_ff == FSH_RES_ABT);
  c_restart:  cover property (st_ff == FSH_CHK && nxt_st == FSH_RD1);
endmodule // fsh_poll_ctrl
`default_nettype wire

// >>> sim/fsh_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Flash device status model (erase suspend held by esusp)
module fsh_flash_model #(
  parameter int          AW    = 26,
  parameter int          RCY   = 10,
  parameter logic [15:0] ARRAY = 16'h5ac3
)(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          load,
  input  wire logic [1:0]    op,
  input  wire logic [7:0]    run_reads,
  input  wire logic          esusp,
  input  wire logic [AW-1:0] addr,
  input  wire logic          ce_n,
  input  wire logic          oe_n,
  input  wire logic          we_n,
  input  wire logic [15:0]   dq_o,
  output logic [15:0]        dq_i,
  output logic               ready_busy_n
);
  logic        busy_ff, tog1_ff, tog2_ff, tmo_ff, abt_ff, rd_ff, we_ff, sec_ff;
  logic [1:0]  op_ff, unlk_ff;
  logic [7:0]  cnt_ff;
  logic [15:0] last_ff;
  int          rcy_ff;
  wire         rd     = ~ce_n & ~oe_n;
  wire         in_sec = (addr[AW-1:16] == '0);
  wire         ers    = (op_ff == 2'h1);
  // Reserved bits carry a changing pattern so a missing mask shows up
  wire [15:0]  stat   = {~last_ff[15:8], ~ers & ~ARRAY[7], tog1_ff, tmo_ff, ~last_ff[4],
                         ers, ers & in_sec & tog2_ff, abt_ff, ~last_ff[0]};
  // Suspended erase: status only inside the sector, array data elsewhere
  wire         held   = esusp & ers;
  wire [15:0]  sstat  = {~last_ff[15:8], 1'b1, tog1_ff, 1'b0, ~last_ff[4],
                         1'b0, in_sec & tog2_ff, 1'b0, ~last_ff[0]};
  // Released bus shows the inverse of the last value, never a stale copy
  assign dq_i         = rd ? ((busy_ff && !(held && !in_sec)) ? (held ? sstat : stat) : ARRAY)
                           : ~last_ff;
  assign ready_busy_n = ~busy_ff | held;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {busy_ff, tog1_ff, tog2_ff, tmo_ff, abt_ff, rd_ff, we_ff, sec_ff} <= '0;
      {op_ff, unlk_ff, cnt_ff, last_ff} <= '0;
      rcy_ff <= 0;
    end
    else
    begin
      rd_ff   <= rd;
      we_ff   <= ~we_n;
      last_ff <= dq_i;
      if (rd)
        sec_ff <= in_sec;
      if (load)
      begin
        {busy_ff, op_ff, cnt_ff} <= {1'b1, op, 8'h00};
        tmo_ff <= (op == 2'h2);
        abt_ff <= (op == 2'h3);
      end
      else if (rd_ff && !rd && busy_ff)
      begin
        tog1_ff <= tog1_ff ^ ~held;
        tog2_ff <= tog2_ff ^ (ers & sec_ff);
        cnt_ff  <= cnt_ff + 8'h01;
        if (run_reads != 8'h00 && cnt_ff + 8'h01 == run_reads)
          busy_ff <= 1'b0;
      end
      if (we_ff && we_n)
      begin
        if (dq_o == 16'h00aa && addr[15:0] == 16'h0555)
          unlk_ff <= 2'h1;
        else if (dq_o == 16'h0055 && addr[15:0] == 16'h02aa && unlk_ff == 2'h1)
          unlk_ff <= 2'h2;
        else
        begin
          unlk_ff <= 2'h0;
          // A bare reset does not clear an abort; only the unlocked sequence does
          if (dq_o == 16'h00f0 && (tmo_ff || (abt_ff && unlk_ff == 2'h2)))
          begin
            {tmo_ff, abt_ff} <= 2'h0;
            rcy_ff <= RCY;
          end
        end
      end
      if (rcy_ff != 0)
      begin
        rcy_ff <= rcy_ff - 1;
        if (rcy_ff == 1)
          busy_ff <= 1'b0;
      end
    end
  end
endmodule // fsh_flash_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fsh_poll_pkg::*;
;
  logic        ref_clk, reset_n, poll_start, abandon, susp_en, load, esusp;
  logic [25:0] poll_addr, susp_addr, fl_addr;
  logic [1:0]  op;
  logic [7:0]  run_reads;
  logic        done_ff, busy_ff, ce_n, oe_n, we_n, dq_oe, rb_n;
  fsh_result_t result_ff;
  logic [15:0] status_ff, dq_o, dq_i;
  int          n_fail, samples_checked, n_strobe, s0;
  fsh_poll_ctrl #(.RST_CYC(20)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .poll_start(poll_start),
    .poll_addr(poll_addr), .abandon(abandon), .susp_en(susp_en), .susp_addr(susp_addr), .done_ff(done_ff),
    .result_ff(result_ff), .status_ff(status_ff), .busy_ff(busy_ff), .flash_addr_ff(fl_addr), .ce_n_ff(ce_n),
    .oe_n_ff(oe_n), .we_n_ff(we_n), .dq_o_ff(dq_o), .dq_oe_ff(dq_oe), .dq_i(dq_i), .ready_busy_n(rb_n));
  fsh_flash_model flash (.ref_clk(ref_clk), .reset_n(reset_n), .load(load), .op(op), .run_reads(run_reads),
    .esusp(esusp),
    .addr(fl_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_o(dq_o), .dq_i(dq_i), .ready_busy_n(rb_n));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(negedge ce_n)
    n_strobe++;
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One poll: arm the device, request, wait for done, compare result and masked status
  task automatic poll(input string nm, input logic [1:0] o, input logic [7:0] nr, input logic gb,
                      input logic [25:0] a, input logic ab, input fsh_result_t er,
                      input logic [15:0] m, input logic [15:0] es);
    int i;
    @(negedge ref_clk);
    {op, run_reads, load, poll_addr, abandon} = {o, nr, gb, a, ab};
    @(negedge ref_clk);
    {load, poll_start} = 2'b01;
    @(negedge ref_clk);
    poll_start = 1'b0;
    for (i = 0; i < 5000 && done_ff !== 1'b1; i++)
      @(negedge ref_clk);
    if (i < 5000)
    begin
      chk({nm, " result"}, 16'(result_ff), 16'(er));
      chk({nm, " status"}, status_ff & m, es);
      $display("test %s done", nm);
    end
    else
    begin
      n_fail++;
      end_sim();
    end
  endtask
  initial
  begin
    {reset_n, poll_start, abandon, susp_en, load, esusp, op, run_reads} = '0;
    {poll_addr, susp_addr} = '0;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    chk("reset strobes", 16'({ce_n, oe_n, we_n, dq_oe, busy_ff, done_ff}), 16'h0038);
    poll("idle", 2'h0, 8'h00, 1'b0, 26'h0000100, 1'b0, FSH_RES_OK, 16'hffff, 16'h00c2);
    poll("prog end", 2'h0, 8'h03, 1'b1, 26'h0000100, 1'b0, FSH_RES_OK, 16'hffff, 16'h00c2);
    poll("prog left", 2'h0, 8'h00, 1'b1, 26'h0000100, 1'b1, FSH_RES_LEFT, 16'hffbf, 16'h0000);
    poll("ers in", 2'h1, 8'h00, 1'b1, 26'h0000100, 1'b1, FSH_RES_LEFT, 16'hffbb, 16'h0008);
    poll("ers out", 2'h1, 8'h00, 1'b1, 26'h0010000, 1'b1, FSH_RES_LEFT, 16'hffbf, 16'h0008);
    poll("timeout", 2'h2, 8'h00, 1'b1, 26'h0000100, 1'b0, FSH_RES_TMO, 16'h0020, 16'h0020);
    chk("ready after reset", {15'h0, rb_n}, 16'h0001);
    poll("abort", 2'h3, 8'h00, 1'b1, 26'h0000100, 1'b0, FSH_RES_ABT, 16'h0002, 16'h0002);
    chk("ready after abort", {15'h0, rb_n}, 16'h0001);
    esusp = 1'b1;
    poll("susp prog", 2'h0, 8'h00, 1'b1, 26'h0000100, 1'b1, FSH_RES_LEFT, 16'hffbf, 16'h0000);
    chk("busy in susp prog", {15'h0, rb_n}, 16'h0000);
    poll("ers susp in", 2'h1, 8'h00, 1'b1, 26'h0000100, 1'b0, FSH_RES_OK, 16'hffbb, 16'h0080);
    chk("ready in ers susp", {15'h0, rb_n}, 16'h0001);
    poll("ers susp out", 2'h1, 8'h00, 1'b1, 26'h0010000, 1'b0, FSH_RES_OK, 16'hffff, 16'h00c2);
    esusp = 1'b0;
    {susp_en, susp_addr} = {1'b1, 26'h0001005};
    s0 = n_strobe;
    poll("suspended", 2'h0, 8'h00, 1'b0, 26'h0001000, 1'b0, FSH_RES_REF, 16'h0000, 16'h0000);
    chk("no strobe", 16'(n_strobe - s0), 16'h0000);
    susp_en = 1'b0;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
